/* File: include/lsi2c_defs.svh */
// constants for the light sensor serial bus target and its controller
// assumes a 20 MHz system clock on both ends
`ifndef LSI2C_DEFS_SVH
`define LSI2C_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LSI_CLK_KHZ    20000
`define LSI_TOUT_MS    28
`define LSI_TOUT_CYC   (`LSI_TOUT_MS * `LSI_CLK_KHZ)
`define LSI_TOUT_W     20
`define LSI_FS_KHZ     400
`define LSI_HS_KHZ     2600
`define LSI_FS_HALF    ((`LSI_CLK_KHZ + 2 * `LSI_FS_KHZ - 1) / (2 * `LSI_FS_KHZ))
`define LSI_HS_HALF    ((`LSI_CLK_KHZ + 2 * `LSI_HS_KHZ - 1) / (2 * `LSI_HS_KHZ))
`define LSI_FILT_FS    3'h3
`define LSI_FILT_HS    3'h1

// ----------------------------------------------------------------
// bus codes
// ----------------------------------------------------------------
`define LSI_HS_CODE    5'h01
`define LSI_GCALL      8'h00
`define LSI_GC_RESET   8'h06
`define LSI_ARA        7'h0C
`define LSI_ADDR_HI    5'h11
`define LSI_PART_ID    16'h5AA5 // arbitrary value

// ----------------------------------------------------------------
// device register map, fields and reset values
// ----------------------------------------------------------------
`define LSI_REG_LTH    8'h08
`define LSI_REG_HTH    8'h09
`define LSI_REG_CFG    8'h0A
`define LSI_REG_IBC    8'h0B
`define LSI_REG_FLG    8'h0C
`define LSI_REG_PID    8'h11
`define LSI_CFG_LATCH  3
`define LSI_CFG_POL    2
`define LSI_IBC_BURST  0
`define LSI_FLG_H      1
`define LSI_FLG_L      0
`define LSI_RST_LTH    16'h0000
`define LSI_RST_HTH    16'h0000
`define LSI_RST_CFG    16'h0000
`define LSI_RST_IBC    16'h0000

// ----------------------------------------------------------------
// controller command port
// ----------------------------------------------------------------
`define LSI_H_CMD      4'h0
`define LSI_H_STAT     4'h1
`define LSI_H_CTRL     4'h2
`define LSI_H_OP_LO    8
`define LSI_H_OP_HI    9
`define LSI_H_ACKBIT   10
`define LSI_H_HSBIT    0
`define LSI_H_LAST_ST  5'h03
`define LSI_H_LAST_SP  5'h02
`define LSI_H_LAST_BY  5'h11

`endif

/* File: include/lsi2c_pkg.sv */
// types shared by the serial bus target, its filter and the controller
// assumes lsi2c_defs.svh for all numeric constants
package lsi2c_pkg;

	// ----------------------------------------------------------------
	// target
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		T_IDLE = 3'h0,
		T_ADDR = 3'h1,
		T_AACK = 3'h3,
		T_RX   = 3'h2,
		T_RACK = 3'h6,
		T_TX   = 3'h7,
		T_TACK = 3'h5
	} lsi_tst_t;

	typedef enum logic [1:0] {
		M_REG   = 2'h0,
		M_GC    = 2'h1,
		M_ALERT = 2'h3
	} lsi_mode_t;

	typedef struct packed {
		lsi_tst_t        state;
		lsi_mode_t       mode;
		logic            scl_q;
		logic            sda_q;
		logic [1:0]      strap_s1;
		logic [1:0]      strap_s2;
		logic [3:0]      cnt;
		logic [7:0]      sh;
		logic            rd;
		logic [1:0]      bidx;
		logic [7:0]      msb;
		logic [7:0]      ptr;
		logic [7:0]      ptr_base;
		logic            ack;
		logic            gc_pend;
		logic            sda_drv;
		logic            hs;
		logic [19:0]     tout;
		logic [15:0]     lth;
		logic [15:0]     hth;
		logic [15:0]     cfg;
		logic [15:0]     ibc;
		logic            flag_h;
		logic            flag_l;
		logic            int_act;
		logic            int_level;
	} lsi_tgt_t;

	typedef struct packed {
		logic [1:0]      s1;
		logic [1:0]      s2;
		logic [1:0][2:0] cnt;
		logic [1:0]      out;
	} lsi_filt_t;

	// ----------------------------------------------------------------
	// controller
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_STOP  = 2'h1,
		OP_WRITE = 2'h3,
		OP_READ  = 2'h2
	} lsi_op_t;

	typedef struct packed {
		lsi_op_t         op;
		logic            busy;
		logic [4:0]      step;
		logic [4:0]      div;
		logic [8:0]      tx;
		logic [8:0]      rx;
		logic            hs;
		logic            scl_low;
		logic            sda_low;
		logic            sda_s1;
		logic            sda_s2;
		logic            int_s1;
		logic            int_s2;
		logic [15:0]     rdata;
	} lsi_host_t;

endpackage

/* File: include/lsi2c_if.sv */
// two-wire bus plus interrupt line between controller and sensor target
// resolves the open-drain wires from the enables; idle level is high
`timescale 1ns/1ps
interface lsi2c_if;
	logic scl_host_o;
	logic scl_host_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic int_line;
	logic scl;
	logic sda;

	assign scl = ~(scl_host_oe & ~scl_host_o);
	assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

	modport host (
		output scl_host_o,
		output scl_host_oe,
		output sda_host_o,
		output sda_host_oe,
		input  sda,
		input  int_line
	);

	modport device (
		output sda_dev_o,
		output sda_dev_oe,
		output int_line,
		input  scl,
		input  sda
	);
endinterface

/* File: verilog/lsi2c_filter.sv */
// two-line input synchroniser and spike filter for the target
// assumes raw scl/sda pins asynchronous to clk_sys
`timescale 1ns/1ps
`include "lsi2c_defs.svh"
module lsi2c_filter (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// pins and mode
	input  wire logic scl_in,
	input  wire logic sda_in,
	input  wire logic hs,
	// filtered levels
	output logic      scl_f,
	output logic      sda_f
);
	lsi2c_pkg::lsi_filt_t r;
	lsi2c_pkg::lsi_filt_t n;
	logic [2:0]           lim;

	always_comb
	begin
		n = r;
		// shorter acceptance window in high-speed mode
		lim = hs ? `LSI_FILT_HS : `LSI_FILT_FS;
		n.s1 = {scl_in, sda_in};
		n.s2 = r.s1;
		for (int i = 0; i < 2; i++)
		begin
			if (r.s2[i] == r.out[i])
				n.cnt[i] = 3'h0;
			else if (r.cnt[i] >= lim - 3'h1)
			begin
				n.out[i] = r.s2[i];
				n.cnt[i] = 3'h0;
			end
			else
				n.cnt[i] = r.cnt[i] + 3'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			r <= '{s1: 2'h3, s2: 2'h3, cnt: '0, out: 2'h3};
		else
			r <= n;
	end

	assign scl_f = r.out[1];
	assign sda_f = r.out[0];
endmodule

/* File: verilog/lsi2c_target.sv */
// serial bus target of the light sensor: register map, high-speed entry,
// burst reads, general-call reset and alert response
// assumes a controller on lsi2c_if and conversion logic on the user side
`timescale 1ns/1ps
`include "lsi2c_defs.svh"

// Notes on behaviour
// - controller sends high-speed code at 400 kHz
// - recognise high-speed code, no ack, fast filter
// - after repeated start, same framing, faster clock
// - controller keeps high-speed with repeated starts
// - stop leaves high-speed, normal filtering again
// - burst: pointer advances after each register read
// - auto-increment only with burst enable set
// - stop restores pointer to written value
// - general call then 06h resets registers
// - answer alert address only in latched mode
// - ignore alert address in transparent mode
// - alert: ack, send own address, arbitrate
// - lost arbitration: stop, interrupt stays active
// - won arbitration: release interrupt output
// - controller repeats alert until interrupt clears
// - alert byte ends with high flag
// - alert leaves both flags unchanged
// - alert low address bits from strap pins
// - pointer kept across transactions
// - clock low for 28 ms resets bus logic
// - registers move high byte first, each acked
module lsi2c_target #(
	parameter int unsigned  TOUT_CYC = `LSI_TOUT_CYC,
	parameter logic [15:0]  PART_ID  = `LSI_PART_ID
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// serial bus
	lsi2c_if.device               bus,
	// address strap pins
	input  wire logic             strap_addr_bit1,
	input  wire logic             strap_addr_bit0,
	// conversion side
	input  wire logic             set_high_flag,
	input  wire logic             set_low_flag,
	input  wire logic [7:0][15:0] result_regs,
	// configuration and status out
	output logic      [15:0]      low_threshold,
	output logic      [15:0]      high_threshold,
	output logic      [15:0]      conversion_config,
	output logic      [15:0]      interrupt_bus_config,
	output logic                  hs_mode,
	output logic                  high_flag_bit,
	output logic                  low_flag
);
	lsi2c_pkg::lsi_tgt_t r;
	lsi2c_pkg::lsi_tgt_t n;
	logic                scl_f;
	logic                sda_f;
	logic                rise;
	logic                fall;
	logic                start;
	logic                stop;
	logic                act;
	logic [6:0]          own;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic lsi2c_pkg::lsi_tgt_t tgt_rst();
		lsi2c_pkg::lsi_tgt_t t;
		t           = '0;
		t.scl_q     = 1'b1;
		t.sda_q     = 1'b1;
		t.lth       = `LSI_RST_LTH;
		t.hth       = `LSI_RST_HTH;
		t.cfg       = `LSI_RST_CFG;
		t.ibc       = `LSI_RST_IBC;
		t.int_level = ~t.cfg[`LSI_CFG_POL];
		return t;
	endfunction

	localparam lsi2c_pkg::lsi_tgt_t TGT_RST = tgt_rst();

	function automatic logic [15:0] rd_reg(input logic [7:0] a);
		logic [15:0] v;
		v = 16'h0000;
		if (a < `LSI_REG_LTH)
			v = result_regs[a[2:0]];
		else
			case (a)
				`LSI_REG_LTH: v = r.lth;
				`LSI_REG_HTH: v = r.hth;
				`LSI_REG_CFG: v = r.cfg;
				`LSI_REG_IBC: v = r.ibc;
				`LSI_REG_FLG: v = {14'h0000, r.flag_h, r.flag_l};
				`LSI_REG_PID: v = PART_ID;
				default:      v = 16'h0000;
			endcase
		return v;
	endfunction

	// next byte to shift out, for a register or the alert answer
	function automatic logic [7:0] tx_byte(input lsi2c_pkg::lsi_tgt_t s,
	                                       input logic [6:0] adr);
		logic [15:0] w;
		w = rd_reg(s.ptr);
		if (s.mode == lsi2c_pkg::M_ALERT)
			return {adr, s.flag_h};
		return (s.bidx == 2'h0) ? w[15:8] : w[7:0];
	endfunction

	lsi2c_filter u_filter (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.scl_in  (bus.scl),
		.sda_in  (bus.sda),
		.hs      (r.hs),
		.scl_f   (scl_f),
		.sda_f   (sda_f)
	);

	// ----------------------------------------------------------------
	// bus engine
	// ----------------------------------------------------------------
	always_comb
	begin
		n       = r;
		n.scl_q = scl_f;
		n.sda_q = sda_f;
		rise    = scl_f & ~r.scl_q;
		fall    = ~scl_f & r.scl_q;
		start   = scl_f & r.scl_q & r.sda_q & ~sda_f;
		stop    = scl_f & r.scl_q & ~r.sda_q & sda_f;
		n.strap_s1 = {strap_addr_bit1, strap_addr_bit0};
		n.strap_s2 = r.strap_s1;
		own     = {`LSI_ADDR_HI, r.strap_s2};

		case (r.state)
			lsi2c_pkg::T_IDLE:
				n.sda_drv = 1'b0;
			lsi2c_pkg::T_ADDR, lsi2c_pkg::T_RX:
			begin
				if (rise)
				begin
					n.sh  = {r.sh[6:0], sda_f};
					n.cnt = r.cnt + 4'h1;
				end
				else if (fall && r.cnt == 4'h8)
				begin
					n.cnt     = 4'h0;
					n.sda_drv = 1'b1;
					n.state   = (r.state == lsi2c_pkg::T_ADDR) ?
					            lsi2c_pkg::T_AACK : lsi2c_pkg::T_RACK;
					if (r.state == lsi2c_pkg::T_ADDR)
					begin
						n.bidx = 2'h0;
						n.rd   = r.sh[0];
						if (r.sh[7:3] == `LSI_HS_CODE)
						begin
							n.hs      = 1'b1;
							n.sda_drv = 1'b0;
							n.state   = lsi2c_pkg::T_IDLE;
						end
						else if (r.sh[7:1] == own)
							n.mode = lsi2c_pkg::M_REG;
						else if (r.sh == `LSI_GCALL)
							n.mode = lsi2c_pkg::M_GC;
						else if (r.sh == {`LSI_ARA, 1'b1} && r.cfg[`LSI_CFG_LATCH] &&
						         r.int_act)
							n.mode = lsi2c_pkg::M_ALERT;
						else
						begin
							n.sda_drv = 1'b0;
							n.state   = lsi2c_pkg::T_IDLE;
						end
					end
					else if (r.mode == lsi2c_pkg::M_GC)
					begin
						if (r.sh == `LSI_GC_RESET)
							n.gc_pend = 1'b1;
						else
						begin
							n.sda_drv = 1'b0;
							n.state   = lsi2c_pkg::T_IDLE;
						end
					end
					else if (r.bidx == 2'h0)
					begin
						n.ptr      = r.sh;
						n.ptr_base = r.sh;
						n.bidx     = 2'h1;
					end
					else if (r.bidx == 2'h1)
					begin
						n.msb  = r.sh;
						n.bidx = 2'h2;
					end
					else
					begin
						n.bidx = 2'h1;
						case (r.ptr)
							`LSI_REG_LTH: n.lth = {r.msb, r.sh};
							`LSI_REG_HTH: n.hth = {r.msb, r.sh};
							`LSI_REG_CFG: n.cfg = {r.msb, r.sh};
							`LSI_REG_IBC: n.ibc = {r.msb, r.sh};
							`LSI_REG_FLG:
							begin
								// write one to clear; a new event below still wins
								if (r.sh[`LSI_FLG_H])
									n.flag_h = 1'b0;
								if (r.sh[`LSI_FLG_L])
									n.flag_l = 1'b0;
							end
							default: n.bidx = 2'h1;
						endcase
					end
				end
			end
			lsi2c_pkg::T_AACK:
				if (fall)
				begin
					n.cnt = 4'h0;
					if (r.rd)
					begin
						n.sh      = tx_byte(r, own);
						n.sda_drv = ~n.sh[7];
						n.state   = lsi2c_pkg::T_TX;
					end
					else
					begin
						n.sda_drv = 1'b0;
						n.state   = lsi2c_pkg::T_RX;
					end
				end
			lsi2c_pkg::T_RACK:
				if (fall)
				begin
					n.sda_drv = 1'b0;
					n.state   = lsi2c_pkg::T_RX;
					if (r.gc_pend)
					begin
						n = TGT_RST;
						n.scl_q = scl_f;
						n.sda_q = sda_f;
						n.strap_s1 = {strap_addr_bit1, strap_addr_bit0};
						n.strap_s2 = r.strap_s1;
					end
				end
			lsi2c_pkg::T_TX:
				if (rise)
				begin
					n.cnt = r.cnt + 4'h1;
					// released a one but the line is low: a lower address wins
					if (r.mode == lsi2c_pkg::M_ALERT && !r.sda_drv && !sda_f)
						n.state = lsi2c_pkg::T_IDLE;
				end
				else if (fall)
				begin
					if (r.cnt == 4'h8)
					begin
						n.sda_drv = 1'b0;
						n.state   = lsi2c_pkg::T_TACK;
						if (r.mode == lsi2c_pkg::M_ALERT)
							n.int_act = 1'b0;
						else if (r.bidx == 2'h0)
							n.bidx = 2'h1;
						else
						begin
							n.bidx = 2'h0;
							if (r.ibc[`LSI_IBC_BURST])
								n.ptr = r.ptr + 8'h01;
						end
					end
					else
					begin
						n.sh      = {r.sh[6:0], 1'b0};
						n.sda_drv = ~r.sh[6];
					end
				end
			lsi2c_pkg::T_TACK:
				if (rise)
					n.ack = ~sda_f;
				else if (fall)
				begin
					n.cnt = 4'h0;
					if (r.ack && r.mode == lsi2c_pkg::M_REG)
					begin
						n.sh      = tx_byte(r, own);
						n.sda_drv = ~n.sh[7];
						n.state   = lsi2c_pkg::T_TX;
					end
					else
						n.state = lsi2c_pkg::T_IDLE;
				end
			default:
				n.state = lsi2c_pkg::T_IDLE;
		endcase

		if (start)
		begin
			n.state   = lsi2c_pkg::T_ADDR;
			n.cnt     = 4'h0;
			n.sh      = 8'h00;
			n.sda_drv = 1'b0;
			n.gc_pend = 1'b0;
		end
		if (stop)
		begin
			n.state   = lsi2c_pkg::T_IDLE;
			n.hs      = 1'b0;
			n.ptr     = r.ptr_base;
			n.sda_drv = 1'b0;
			n.gc_pend = 1'b0;
		end

		// clock stuck low: drop back to idle and free the data line
		if (scl_f)
			n.tout = '0;
		else if (r.tout != TOUT_CYC[19:0])
			n.tout = r.tout + 20'h0_0001;
		if (r.tout == TOUT_CYC[19:0] - 20'h0_0001)
		begin
			n.state   = lsi2c_pkg::T_IDLE;
			n.sda_drv = 1'b0;
		end

		// events set after any clear so that they are never lost
		if (set_high_flag)
			n.flag_h = 1'b1;
		if (set_low_flag)
			n.flag_l = 1'b1;
		if (set_high_flag || set_low_flag)
			n.int_act = 1'b1;
		act = n.cfg[`LSI_CFG_LATCH] ? n.int_act : (n.flag_h | n.flag_l);
		n.int_level = ~(act ^ n.cfg[`LSI_CFG_POL]);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			r <= TGT_RST;
		else
			r <= n;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign bus.sda_dev_o          = 1'b0;
	assign bus.sda_dev_oe         = r.sda_drv;
	assign bus.int_line           = r.int_level;
	assign low_threshold          = r.lth;
	assign high_threshold         = r.hth;
	assign conversion_config      = r.cfg;
	assign interrupt_bus_config   = r.ibc;
	assign hs_mode                = r.hs;
	assign high_flag_bit          = r.flag_h;
	assign low_flag               = r.flag_l;
endmodule

/* File: verilog/lsi2c_host.sv */
// bus controller end: byte-level start, stop, write and read commands
// assumes software on a plain register port in the clk_sys domain
`timescale 1ns/1ps
`include "lsi2c_defs.svh"
module lsi2c_host (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// serial bus
	lsi2c_if.host            bus,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata
);
	lsi2c_pkg::lsi_host_t r;
	lsi2c_pkg::lsi_host_t n;
	logic [4:0]           half;
	logic [4:0]           last;

	// line levels for one half period of a command
	function automatic logic [1:0] drive(input lsi2c_pkg::lsi_op_t op,
	                                     input logic [4:0] st,
	                                     input logic [8:0] tx);
		case (op)
			lsi2c_pkg::OP_START:
				case (st)
					5'h00:   return 2'b10;
					5'h01:   return 2'b00;
					5'h02:   return 2'b01;
					default: return 2'b11;
				endcase
			lsi2c_pkg::OP_STOP:
				case (st)
					5'h00:   return 2'b11;
					5'h01:   return 2'b01;
					default: return 2'b00;
				endcase
			default:
				return {~st[0], ~tx[4'h8 - st[4:1]]};
		endcase
	endfunction

	// ----------------------------------------------------------------
	// sequencer and register port
	// ----------------------------------------------------------------
	always_comb
	begin
		n        = r;
		n.sda_s1 = bus.sda;
		n.sda_s2 = r.sda_s1;
		n.int_s1 = bus.int_line;
		n.int_s2 = r.int_s1;
		// code byte at normal speed, fast once software asks, until a stop completes
		half = r.hs ? 5'(`LSI_HS_HALF) : 5'(`LSI_FS_HALF);
		case (r.op)
			lsi2c_pkg::OP_START: last = `LSI_H_LAST_ST;
			lsi2c_pkg::OP_STOP:  last = `LSI_H_LAST_SP;
			default:             last = `LSI_H_LAST_BY;
		endcase

		if (r.busy)
		begin
			n.div = r.div + 5'h01;
			if (r.div == half - 5'h01)
			begin
				n.div = 5'h00;
				if ((r.op == lsi2c_pkg::OP_WRITE || r.op == lsi2c_pkg::OP_READ) && r.step[0])
					n.rx = {r.rx[7:0], r.sda_s2};
				if (r.step == last)
				begin
					n.busy = 1'b0;
					if (r.op == lsi2c_pkg::OP_STOP)
						n.hs = 1'b0;
				end
				else
				begin
					n.step = r.step + 5'h01;
					{n.scl_low, n.sda_low} = drive(r.op, n.step, r.tx);
				end
			end
		end
		else if (reg_wr && reg_addr == `LSI_H_CMD)
		begin
			n.op   = lsi2c_pkg::lsi_op_t'(reg_wdata[`LSI_H_OP_HI:`LSI_H_OP_LO]);
			n.busy = 1'b1;
			n.step = 5'h00;
			n.div  = 5'h00;
			n.tx   = (n.op == lsi2c_pkg::OP_READ) ?
			         {8'hFF, ~reg_wdata[`LSI_H_ACKBIT]} : {reg_wdata[7:0], 1'b1};
			{n.scl_low, n.sda_low} = drive(n.op, 5'h00, n.tx);
		end
		if (reg_wr && reg_addr == `LSI_H_CTRL)
			n.hs = reg_wdata[`LSI_H_HSBIT];

		n.rdata = 16'h0000;
		if (reg_rd)
			case (reg_addr)
				`LSI_H_STAT: n.rdata = {r.rx[8:1], 5'h00, r.int_s2, ~r.rx[0], r.busy};
				`LSI_H_CTRL: n.rdata = {15'h0000, r.hs};
				default:     n.rdata = 16'h0000;
			endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			r <= '{sda_s1: 1'b1, sda_s2: 1'b1, int_s1: 1'b1, int_s2: 1'b1,
			       rx: 9'h1FF, tx: 9'h1FF, op: lsi2c_pkg::OP_STOP, default: '0};
		else
			r <= n;
	end

	assign bus.scl_host_o  = 1'b0;
	assign bus.scl_host_oe = r.scl_low;
	assign bus.sda_host_o  = 1'b0;
	assign bus.sda_host_oe = r.sda_low;
	assign reg_rdata       = r.rdata;
endmodule

/* File: tb/lsi2c_asserts.sv */
// checker on the two-wire link between the controller and the sensor target
// assumes plain interface signals and an active-low interrupt line
`timescale 1ns/1ps
module lsi2c_asserts #(
	parameter int unsigned TOUT_CYC = 200
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// link wires
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_dev_oe,
	input wire logic int_line
);
	// ----
	// frame tracking on the raw wires
	// ----
	logic       scl_q;
	logic       sda_q;
	logic       in_frame;
	logic [4:0] cnt;
	logic [7:0] sh;
	logic [7:0] b0;
	logic [9:0] low_cnt;
	logic       rise;
	logic       start;
	logic       stop;

	assign rise  = scl & ~scl_q;
	assign start = scl & scl_q & sda_q & ~sda;
	assign stop  = scl & scl_q & ~sda_q & sda;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
			in_frame <= 1'b0;
			cnt      <= 5'h00;
			sh       <= 8'h00;
			b0       <= 8'h00;
			low_cnt  <= 10'h000;
		end
		else
		begin
			scl_q   <= scl;
			sda_q   <= sda;
			low_cnt <= (scl || low_cnt == 10'h3ff) ? {10{~scl}} & low_cnt : low_cnt + 10'h001;
			if (start)
			begin
				in_frame <= 1'b1;
				cnt      <= 5'h00;
			end
			else if (stop)
				in_frame <= 1'b0;
			else if (rise)
			begin
				cnt <= (cnt == 5'h1f) ? cnt : cnt + 5'h01;
				sh  <= {sh[6:0], sda};
				if (cnt == 5'h07)
					b0 <= {sh[6:0], sda};
			end
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// ----
	// link properties
	// ----
	hs_noack_a: assert property (rise && cnt == 5'h08 && b0[7:3] == 5'h01 |-> sda)
		else $error("high-speed code acknowledged");
	gc_ack_a: assert property (rise && cnt == 5'h11 && b0 == 8'h00 && sh == 8'h06 |-> !sda)
		else $error("reset call not acknowledged");
	stray_noack_a:
		assert property (rise && cnt == 5'h08 && b0[7:3] != 5'h11 && b0[7:3] != 5'h01
			&& b0 != 8'h00 && b0 != 8'h19 |-> sda)
		else $error("foreign address acknowledged");
	addr_quiet_a: assert property (in_frame && cnt < 5'h08 |-> !sda_dev_oe)
		else $error("target drives during address byte");
	idle_release_a: assert property (!in_frame |-> !sda_dev_oe)
		else $error("target drives outside a frame");
	ara_idle_a: assert property (rise && cnt == 5'h08 && b0 == 8'h19 && int_line |-> sda)
		else $error("alert answered without pending interrupt");
	tout_release_a: assert property (low_cnt == 10'(TOUT_CYC + 20) |-> !sda_dev_oe)
		else $error("data line held after clock timeout");
	ack_hold_a: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*6])
		else $error("target drive shorter than a bit");
endmodule

/* File: tb/tb_top.sv */
// bench: controller and sensor target joined over the link interface
// assumes software-style commands through the controller register port
`timescale 1ns/1ps
module tb_top;
	logic             clk_sys         = 1'b0;
	logic             rst_n           = 1'b0;
	logic [3:0]       reg_addr        = 4'h0;
	logic [15:0]      reg_wdata       = 16'h0000;
	logic             reg_wr          = 1'b0;
	logic             reg_rd          = 1'b0;
	logic [15:0]      reg_rdata;
	logic             strap_addr_bit1 = 1'b1;
	logic             strap_addr_bit0 = 1'b0;
	logic             set_high_flag   = 1'b0;
	logic             set_low_flag    = 1'b0;
	logic [7:0][15:0] res;
	logic [15:0]      hth;
	logic [15:0]      lth;
	logic [15:0]      cfg;
	logic [15:0]      ibc;
	logic             hs_mode;
	logic             high_flag_bit;
	logic             low_flag;
	logic [15:0]      v;
	int               n_errors        = 0;
	int               n_compared      = 0;

	lsi2c_if bus ();
	always #25 clk_sys = ~clk_sys;

	lsi2c_host i_lsi2c_host (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	lsi2c_target #(.TOUT_CYC(200)) i_lsi2c_target (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
		.strap_addr_bit1(strap_addr_bit1), .strap_addr_bit0(strap_addr_bit0),
		.set_high_flag(set_high_flag), .set_low_flag(set_low_flag), .result_regs(res),
		.low_threshold(lth), .high_threshold(hth), .conversion_config(cfg),
		.interrupt_bus_config(ibc),
		.hs_mode(hs_mode), .high_flag_bit(high_flag_bit), .low_flag(low_flag));
	lsi2c_asserts #(.TOUT_CYC(200)) i_lsi2c_asserts (.clk_sys(clk_sys), .rst_n(rst_n),
		.scl(bus.scl), .sda(bus.sda), .sda_dev_oe(bus.sda_dev_oe), .int_line(bus.int_line));

	// ----
	// port and bus tasks
	// ----
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// issue one command and poll until the controller is idle again
	task automatic cmd(input lsi2c_pkg::lsi_op_t op, input logic [7:0] b, input logic ak);
		wr(4'h0, {5'h00, ak, op, b});
		for (int i = 0; i < 2000; i++)
		begin
			rd(4'h1);
			if (v[0] === 1'b0)
				break;
		end
		chk("busy", 16'h0000, {15'h0000, v[0]});
	endtask
	task automatic bus_start;
		cmd(lsi2c_pkg::OP_START, 8'h00, 1'b0);
	endtask
	task automatic bus_stop;
		cmd(lsi2c_pkg::OP_STOP, 8'h00, 1'b0);
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic wb(input logic [7:0] b, input logic ack);
		cmd(lsi2c_pkg::OP_WRITE, b, 1'b0);
		chk("ack", {15'h0000, ack}, {15'h0000, v[1]});
	endtask
	// pointer write, optionally followed by one register value
	task automatic dev_wr(input logic [7:0] p, input logic [15:0] d, input logic wd);
		bus_start;
		wb(8'h8c, 1'b1);
		wb(p, 1'b1);
		if (wd)
		begin
			wb(d[15:8], 1'b1);
			wb(d[7:0], 1'b1);
		end
		bus_stop;
	endtask
	// reads n registers in one transfer, e[0] first
	task automatic dev_rd(input int n, input logic [2:0][15:0] e);
		bus_start;
		wb(8'h8d, 1'b1);
		for (int i = 0; i < 2 * n; i++)
		begin
			cmd(lsi2c_pkg::OP_READ, 8'h00, i != 2 * n - 1);
			chk("rx", {8'h00, i[0] ? e[i / 2][7:0] : e[i / 2][15:8]}, {8'h00, v[15:8]});
		end
		bus_stop;
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_regs;
		dev_wr(8'h09, 16'h1234, 1'b1);
		chk("hth", 16'h1234, hth);
		dev_rd(1, {3{16'h1234}});
		dev_rd(1, {3{16'h1234}});
		dev_wr(8'h00, 16'hffff, 1'b1);
		dev_rd(1, {3{res[0]}});
		bus_start;
		wb(8'h90, 1'b0);
		bus_stop;
	endtask
	task automatic t_burst;
		dev_wr(8'h0b, 16'h0001, 1'b1);
		chk("ibc", 16'h0001, ibc);
		dev_wr(8'h02, 16'h0000, 1'b0);
		dev_rd(3, {res[4], res[3], res[2]});
		dev_rd(1, {3{res[2]}});
		dev_wr(8'h0b, 16'h0000, 1'b1);
		dev_wr(8'h05, 16'h0000, 1'b0);
		dev_rd(2, {3{res[5]}});
	endtask
	task automatic t_hs;
		bus_start;
		wb(8'h0a, 1'b0);
		chk("hs", 16'h0001, {15'h0000, hs_mode});
		wr(4'h2, 16'h0001);
		bus_start;
		wb(8'h8c, 1'b1);
		wb(8'h09, 1'b1);
		wb(8'h56, 1'b1);
		wb(8'h78, 1'b1);
		chk("hs", 16'h0001, {15'h0000, hs_mode});
		dev_rd(1, {3{16'h5678}});
		chk("hs", 16'h0000, {15'h0000, hs_mode});
	endtask
	task automatic t_gc;
		dev_wr(8'h08, 16'h0abc, 1'b1);
		bus_start;
		wb(8'h00, 1'b1);
		wb(8'h06, 1'b1);
		bus_stop;
		chk("hth", 16'h0000, hth);
		chk("lth", 16'h0000, lth);
	endtask
	task automatic t_alert;
		dev_wr(8'h0a, 16'h0008, 1'b1);
		chk("cfg", 16'h0008, cfg);
		set_high_flag <= 1'b1;
		@(posedge clk_sys);
		set_high_flag <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk("int", 16'h0000, {15'h0000, bus.int_line});
		// the controller sends zeros over the reply so the target loses
		bus_start;
		wb(8'h19, 1'b1);
		cmd(lsi2c_pkg::OP_WRITE, 8'h00, 1'b0);
		bus_stop;
		chk("int", 16'h0000, {15'h0000, bus.int_line});
		bus_start;
		wb(8'h19, 1'b1);
		cmd(lsi2c_pkg::OP_READ, 8'h00, 1'b0);
		chk("reply", 16'h008d, {8'h00, v[15:8]});
		bus_stop;
		chk("int", 16'h0001, {15'h0000, bus.int_line});
		chk("flags", 16'h0002, {14'h0000, high_flag_bit, low_flag});
		bus_start;
		wb(8'h19, 1'b0);
		bus_stop;
		dev_wr(8'h0a, 16'h0000, 1'b1);
		// event pending, mode alone must silence it
		set_low_flag <= 1'b1;
		@(posedge clk_sys);
		set_low_flag <= 1'b0;
		bus_start;
		wb(8'h19, 1'b0);
		bus_stop;
		chk("int", 16'h0000, {15'h0000, bus.int_line});
		dev_wr(8'h0c, 16'h0003, 1'b1);
		chk("int", 16'h0001, {15'h0000, bus.int_line});
	endtask
	// clock held low while the target drives a bit: it must let go and forget
	task automatic t_tout;
		bus_start;
		wb(8'h8d, 1'b1);
		bus_start;
		repeat (260) @(posedge clk_sys);
		chk("drive", 16'h0000, {15'h0000, bus.sda_dev_oe});
		wb(8'h8c, 1'b0);
		bus_stop;
	endtask

	task automatic summarize;
		if (n_errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		for (int i = 0; i < 8; i++)
			res[i] = {8'h10 + 8'(i), 8'(i)};
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_regs;
		t_burst;
		t_hs;
		t_gc;
		t_alert;
		t_tout;
		summarize;
	end

	initial
	begin
		repeat (90000) @(posedge clk_sys);
		n_errors++;
		summarize;
	end
endmodule
